/* tbi_consts.svh */
`ifndef TBI_CONSTS_SVH
`define TBI_CONSTS_SVH
// Register byte addresses
`define TBI_ADDR_CTRL 4'h0
`define TBI_ADDR_STAT 4'h4
`define TBI_ADDR_GAP 4'h8
`define TBI_ADDR_B8 4'hc
// Control register field positions
`define TBI_F_MUXSEL 0
`define TBI_F_CLKDIR 1
`define TBI_F_MAP 2
`define TBI_F_FPCLK 4
`define TBI_F_SMPPOL 5
`define TBI_F_FPKIND 6
`define TBI_F_FPPOL 7
`define TBI_F_DBLCLK 8
`define TBI_F_PHASE 9
`define TBI_F_FHOLE 10
`define TBI_F_PCEN 11
`define TBI_F_IRQEN 12
`define TBI_CTRL_W 13
`define TBI_CTRL_RST 13'h0000
// Status register field positions
`define TBI_F_ERR 0
// Timing: reference clock and line rate in Hz
`define TBI_REF_HZ 100000000
`define TBI_T1_HZ 1544000
`define TBI_NCO_STEP (2 * `TBI_T1_HZ)
// Frame lengths in backplane bits
`define TBI_T1_BITS 193
`define TBI_E1_BITS 256
`define TBI_MUX_BITS 1024
// Slot and bit positions used by the rate mappings
`define TBI_STD_FSLOT 26
`define TBI_FBIT_POS 7
`define TBI_STD_LO_END 15
`define TBI_STD_HI_BEG 17
`define TBI_STD_HI_END 25
`define TBI_CONT_END 24
`endif

/* tbi_pkg.sv */
package tbi_pkg;
    // Operating mode of the transmit backplane
    typedef enum logic [1:0] {
        tbi_md_master = 2'b00,
        tbi_md_slv_t1 = 2'b01,
        tbi_md_slv_e1 = 2'b10,
        tbi_md_mux = 2'b11
    } tbi_mode_t;
    // E1-rate to T1 mapping scheme
    typedef enum logic [1:0] {
        tbi_sc_none = 2'b00,
        tbi_sc_std = 2'b01,
        tbi_sc_fill = 2'b10,
        tbi_sc_cont = 2'b11
    } tbi_scheme_t;
endpackage : tbi_pkg

/* tbi_map.sv */
`timescale 1ns/1ps
`include "tbi_consts.svh"
module tbi_map import tbi_pkg::*; (
    input wire tbi_scheme_t scheme, // Selected mapping
    input wire logic [4:0] slot, // System timeslot of the bit
    input wire logic [2:0] bit_idx, // Bit within slot, 0 is first
    output logic keep, // Bit becomes a line channel bit
    output logic push_f, // Bit position that yields the line F-bit
    output logic save_f // Bit to store as next frame's F-bit
);
    // Slot decode per scheme
    function automatic logic keep_slot(input tbi_scheme_t s, input logic [4:0] t);
        case (s)
            tbi_sc_std: keep_slot = (t != 5'h0 && t <= 5'(`TBI_STD_LO_END)) ||
                (t >= 5'(`TBI_STD_HI_BEG) && t <= 5'(`TBI_STD_HI_END));
            tbi_sc_fill: keep_slot = (t != 5'h0) && (t[1:0] != 2'h0); // Three kept, one filler
            tbi_sc_cont: keep_slot = (t != 5'h0) && (t <= 5'(`TBI_CONT_END));
            default: keep_slot = 1'b0;
        endcase
    endfunction : keep_slot

    // Every scheme but tbi_sc_none emits the F-bit at bit 8 of slot 0; stored or live
    always_comb begin
        keep = keep_slot(scheme, slot);
        push_f = (scheme != tbi_sc_none) && (slot == 5'h0) && (bit_idx == 3'(`TBI_FBIT_POS));
        save_f = (scheme == tbi_sc_std) && (slot == 5'(`TBI_STD_FSLOT)) && (bit_idx == 3'h0);
    end
endmodule : tbi_map

/* tbi_top.sv */
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "tbi_consts.svh"
// What this block does
// - Non-mux, clock slave, map code nonzero: E1-rate slave using chosen scheme.
// - Mux select set: mux bus pins are inputs, same three scheme codes apply.
// - Master drives clock and frame pulse; system aligns data and signalling to them.
// - Master: one bit picks pulse update edge, another picks sampling edge.
// - Differing edge bits move the frame pulse half a clock earlier.
// - Pulse kind bit: every F-bit or only multiframe's first F-bit.
// - Polarity bit selects active high or active low frame pulse.
// - Master full: continuous 1.544 MHz clock over F-bit and 24 channels.
// - Master fractional: clock pulses removed during holed channels.
// - F-bit hole bit removes the clock pulse during the F-bit.
// - Channel holes cover whole channels or bit 8; holed data ignored.
// - Standard map: slots 1-15 to channels 1-15, 17-25 to 16-24.
// - Standard map: F-bit from slot 26 first bit of previous frame.
// - Filler map: F from bit 8, then keep three bytes, drop one.
// - Continuous map: slots 1-24 to channels, F from bit 8.
// - Clock select bit picks single or double rate backplane clock in E1-rate slave and mux modes.
// - Double clock: phase bit picks data edge; pulse on first edge.
// - Slave: pulse spacing not a whole frame multiple sets error flag.
// - Error flag with its enable drives the active-low interrupt.
// - Master: clock and pulse are outputs; slave: both are inputs.
module tbi_top import tbi_pkg::*; #(
    parameter int FIFO_DEPTH = 256, // Line buffer depth in bits, power of two
    parameter int MF_FRAMES = 12 // Frames per multiframe for the pulse
) (
    input wire logic ref_clk, // Block clock, 100 MHz
    input wire logic arst_n, // Asynchronous reset
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic tx_backplane_clock, // Clock pin level
    output logic tx_backplane_clock_drive, // Clock pin driven value
    output logic tx_backplane_clock_oe, // Clock pin enable
    input wire logic tx_backplane_frame_pulse, // Pulse pin level
    output logic tx_backplane_frame_pulse_drive, // Pulse pin driven value
    output logic tx_backplane_frame_pulse_oe, // Pulse pin enable
    input wire logic tx_backplane_serial_in, // Payload bits
    input wire logic tx_backplane_signalling_in, // Signalling bits
    input wire logic mux_bus_clock, // Mux bus clock
    input wire logic mux_bus_frame_pulse, // Mux bus pulse
    input wire logic mux_bus_serial_in, // Mux bus payload
    input wire logic mux_bus_signalling_in, // Mux bus signalling
    output logic line_data, // Line bit
    output logic line_sig, // Line signalling bit
    output logic line_fmark, // Line bit is the F-bit
    output logic line_valid, // Line bit strobe
    output logic irq_n // Interrupt, active low
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [7:0] T1_LAST = 8'(`TBI_T1_BITS - 1);
    localparam logic [7:0] MF_LAST = 8'(MF_FRAMES - 1);

    logic [`TBI_CTRL_W-1:0] ctrl;
    logic [23:0] gap_mask;
    logic [23:0] b8_mask;
    logic err_flag;
    logic done;
    tbi_mode_t mode;
    tbi_scheme_t scheme;

    // Control decode
    wire mux_sel = ctrl[`TBI_F_MUXSEL];
    wire fp_clk_sel = ctrl[`TBI_F_FPCLK];
    wire smp_pol = ctrl[`TBI_F_SMPPOL];
    wire fp_kind = ctrl[`TBI_F_FPKIND];
    wire fp_pol = ctrl[`TBI_F_FPPOL];
    wire ph_sel = ctrl[`TBI_F_PHASE];
    wire pc_en = ctrl[`TBI_F_PCEN];
    wire [23:0] ch_hole = pc_en ? gap_mask : 24'h0; // Channel and bit-8 holes only count with payload enable
    wire [23:0] b8_hole = pc_en ? b8_mask : 24'h0;
    assign scheme = tbi_scheme_t'(ctrl[`TBI_F_MAP +: 2]);

    // Mode selection from mux, direction and map bits
    always_comb begin
        if (mux_sel) begin
            mode = tbi_md_mux;
        end else if (!ctrl[`TBI_F_CLKDIR]) begin
            mode = tbi_md_master;
        end else if (scheme == tbi_sc_none) begin
            mode = tbi_md_slv_t1;
        end else begin
            mode = tbi_md_slv_e1;
        end
    end
    wire master = (mode == tbi_md_master);
    wire dbl = ctrl[`TBI_F_DBLCLK] && (mode == tbi_md_slv_e1 || mode == tbi_md_mux);

    // Bus slave: one wait state, read data captured in the first cycle
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & done;
    wire err_clr = wr_go && (avs_address == `TBI_ADDR_STAT) && avs_writedata[`TBI_F_ERR];
    assign avs_waitrequest = req & ~done;

    function automatic logic [31:0] rd_word(input logic [3:0] a);
        case (a)
            `TBI_ADDR_CTRL: rd_word = {19'h0, ctrl};
            `TBI_ADDR_STAT: rd_word = {31'h0, err_flag};
            `TBI_ADDR_GAP: rd_word = {8'h0, gap_mask};
            `TBI_ADDR_B8: rd_word = {8'h0, b8_mask};
            default: rd_word = 32'h0;
        endcase
    endfunction : rd_word

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            done <= req & ~done;
            if (req && !done) begin
                avs_readdata <= rd_word(avs_address);
            end
        end
    end

    // Writable registers, taken at the edge after the one that ends the wait
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= `TBI_CTRL_RST;
            gap_mask <= 24'h0;
            b8_mask <= 24'h0;
        end else if (wr_go) begin
            case (avs_address)
                `TBI_ADDR_CTRL: ctrl <= avs_writedata[`TBI_CTRL_W-1:0];
                `TBI_ADDR_GAP: gap_mask <= avs_writedata[23:0];
                `TBI_ADDR_B8: b8_mask <= avs_writedata[23:0];
                default: ;
            endcase
        end
    end

    // Pin synchroniser; a level counts once stages two and three agree
    logic [3:0] pin_raw, sy1, sy2, sy3, pin_st;
    assign pin_raw = mux_sel ? {mux_bus_clock, mux_bus_frame_pulse, mux_bus_serial_in, mux_bus_signalling_in}
                             : {tx_backplane_clock, tx_backplane_frame_pulse,
                                tx_backplane_serial_in, tx_backplane_signalling_in};
    wire [3:0] agree = ~(sy2 ^ sy3);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sy1 <= 4'h0;
            sy2 <= 4'h0;
            sy3 <= 4'h0;
            pin_st <= 4'h0;
        end else begin
            sy1 <= pin_raw;
            sy2 <= sy1;
            sy3 <= sy2;
            pin_st <= (agree & sy2) | (~agree & pin_st);
        end
    end
    wire st_clk = pin_st[3];
    wire st_fp = pin_st[2];
    wire st_d = pin_st[1];
    wire st_s = pin_st[0];

    // Rate generator at twice the line rate; every wrap is a half period
    logic [26:0] nco;
    logic clk_lvl;
    logic st_clk_d;
    wire [27:0] nco_sum = {1'b0, nco} + 28'(`TBI_NCO_STEP);
    wire nco_wrap = nco_sum >= 28'(`TBI_REF_HZ);
    wire line_tick = nco_wrap & clk_lvl;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nco <= 27'h0;
            clk_lvl <= 1'b0;
            st_clk_d <= 1'b0;
        end else begin
            nco <= nco_wrap ? 27'(nco_sum - 28'(`TBI_REF_HZ)) : nco_sum[26:0];
            clk_lvl <= clk_lvl ^ nco_wrap;
            st_clk_d <= st_clk;
        end
    end

    // Edges of the backplane clock: own clock as master, pin as slave
    wire m_rise = nco_wrap & ~clk_lvl;
    wire m_fall = nco_wrap & clk_lvl;
    wire rise = master ? m_rise : (st_clk & ~st_clk_d);
    wire fall = master ? m_fall : (~st_clk & st_clk_d);
    wire fp_edge = fp_clk_sel ? rise : fall;
    wire smp_edge = smp_pol ? rise : fall;
    wire launch = smp_pol ? fall : rise;

    // Master frame position and clock holes
    logic [7:0] m_pos;
    logic [7:0] m_frm;
    logic m_fp;
    function automatic logic hole_at(input logic [7:0] p);
        logic [7:0] q;
        q = p - 8'h1;
        if (p == 8'h0) begin
            hole_at = ctrl[`TBI_F_FHOLE];
        end else begin
            hole_at = ch_hole[q[7:3]] | (b8_hole[q[7:3]] & (q[2:0] == 3'h7));
        end
    endfunction : hole_at
    // Process form, so a register write re-evaluates the hole at once
    logic gap_cur;
    always_comb gap_cur = hole_at(m_pos);
    // With unequal edges the pulse is set at the launch before the last bit
    wire [7:0] fp_at = (fp_clk_sel == smp_pol) ? T1_LAST : T1_LAST - 8'h1;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            m_pos <= 8'h0;
            m_frm <= 8'h0;
        end else if (master && launch) begin
            if (m_pos == T1_LAST) begin
                m_pos <= 8'h0; // F-bit plus 24 channels per frame
                m_frm <= (m_frm == MF_LAST) ? 8'h0 : m_frm + 8'h1;
            end else begin
                m_pos <= m_pos + 8'h1;
            end
        end
    end

    // Frame pulse, updated only on its own clock edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            m_fp <= 1'b0;
        end else if (!master) begin
            m_fp <= 1'b0;
        end else if (fp_edge) begin
            m_fp <= (m_pos == fp_at) && (!fp_kind || m_frm == MF_LAST);
        end
    end

    // Pin drive; holes stretch the low phase through the bit
    assign tx_backplane_clock_oe = master;
    assign tx_backplane_frame_pulse_oe = master;
    assign tx_backplane_clock_drive = master & clk_lvl & ~gap_cur;
    assign tx_backplane_frame_pulse_drive = master & (m_fp ^ fp_pol);

    // Slave alignment: pulse caught once, on the first active edge
    logic fp_last, pending, ph, aligned, f_store;
    logic [9:0] s_pos;
    logic [9:0] flen_last;
    wire fp_act = st_fp ^ fp_pol;
    wire fp_new = !master && fp_edge && fp_act && !fp_last;
    wire cur_ph = fp_new ? 1'b0 : ph;
    wire take = !master && smp_edge && (!dbl || cur_ph == ph_sel);
    wire start = pending | fp_new;
    wire [9:0] next_s_pos = (start || s_pos == flen_last) ? 10'h0 : s_pos + 10'h1;
    wire err_evt = take && start && aligned && (s_pos != flen_last);
    always_comb begin
        case (mode)
            tbi_md_slv_e1: flen_last = 10'(`TBI_E1_BITS - 1);
            tbi_md_mux: flen_last = 10'(`TBI_MUX_BITS - 1);
            default: flen_last = 10'(`TBI_T1_BITS - 1);
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fp_last <= 1'b0;
            pending <= 1'b0;
            ph <= 1'b0;
            aligned <= 1'b0;
            s_pos <= 10'h0;
        end else if (master) begin
            pending <= 1'b0;
            aligned <= 1'b0;
        end else begin
            if (fp_edge) begin
                fp_last <= fp_act;
            end
            if (take) begin
                pending <= 1'b0;
            end else if (fp_new) begin
                pending <= 1'b1;
            end
            if (smp_edge && dbl) begin
                ph <= ~cur_ph; // Two active edges per bit
            end
            if (take) begin
                s_pos <= next_s_pos;
                aligned <= aligned | start;
            end
        end
    end

    // Error flag: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_flag <= 1'b0;
        end else begin
            err_flag <= err_evt | (err_flag & ~err_clr);
        end
    end
    assign irq_n = ~(err_flag & ctrl[`TBI_F_IRQEN]);

    // E1-rate mapping; only stream 0 of the mux bus belongs to this link
    logic mp_keep, mp_push_f, mp_save_f;
    wire [4:0] s_slot = (mode == tbi_md_mux) ? next_s_pos[9:5] : next_s_pos[7:3];
    wire stream_ok = (mode != tbi_md_mux) || (next_s_pos[4:3] == 2'h0);
    tbi_map u_map (
        .scheme(scheme),
        .slot(s_slot),
        .bit_idx(next_s_pos[2:0]),
        .keep(mp_keep),
        .push_f(mp_push_f),
        .save_f(mp_save_f)
    );
    wire s_ok = take && (start || aligned) && stream_ok;

    // F-bit of the standard map is held for one frame
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            f_store <= 1'b0;
        end else if (s_ok && mp_save_f) begin
            f_store <= st_d;
        end
    end

    // Bits that enter the line buffer
    logic push;
    logic [2:0] push_word;
    always_comb begin
        push = 1'b0;
        push_word = 3'h0;
        case (mode)
            tbi_md_master: begin
                if (smp_edge && !gap_cur) begin
                    push = 1'b1; // Holed bits are never taken
                    push_word = {st_d, st_s, m_pos == 8'h0};
                end
            end
            tbi_md_slv_t1: begin
                if (take && (start || aligned)) begin
                    push = 1'b1;
                    push_word = {st_d, st_s, next_s_pos == 10'h0};
                end
            end
            tbi_md_slv_e1, tbi_md_mux: begin
                if (s_ok && mp_push_f) begin
                    push = 1'b1;
                    push_word = {(scheme == tbi_sc_std) ? f_store : st_d, 1'b0, 1'b1};
                end else if (s_ok && mp_keep) begin
                    push = 1'b1;
                    push_word = {st_d, st_s, 1'b0};
                end
            end
            default: ;
        endcase
    end

    // Line buffer: primed to half, then drained at the line rate
    logic [2:0] mem [FIFO_DEPTH];
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
    logic primed;
    wire full = (cnt == (AW+1)'(FIFO_DEPTH));
    wire wr = push & ~full; // Overrun drops the newest bit
    wire rd = line_tick & primed & (cnt != '0);
    always_ff @(posedge ref_clk) begin
        if (wr) begin
            mem[wp] <= push_word;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            primed <= 1'b0;
        end else begin
            if (wr) begin
                wp <= wp + 1'b1;
            end
            if (rd) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
            if (cnt >= (AW+1)'(FIFO_DEPTH / 2)) begin
                primed <= 1'b1; // Half full absorbs the discarded slots
            end else if (line_tick && cnt == '0) begin
                primed <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_valid <= 1'b0;
            {line_data, line_sig, line_fmark} <= 3'h0;
        end else begin
            line_valid <= rd;
            if (rd) begin
                {line_data, line_sig, line_fmark} <= mem[rp];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    pin_dir_a: assert property (master == (tx_backplane_clock_oe && tx_backplane_frame_pulse_oe))
        else $error("pin direction does not follow mode");
    hole_clk_a: assert property (master && gap_cur |-> !tx_backplane_clock_drive)
        else $error("clock pulse during a hole");
    fbit_hole_a: assert property (master && m_pos == 8'h0 && ctrl[`TBI_F_FHOLE] |-> !tx_backplane_clock_drive)
        else $error("clock pulse during holed F-bit");
    full_clk_a: assert property (master && !gap_cur && $rose(clk_lvl) |-> tx_backplane_clock_drive)
        else $error("missing clock pulse");
    samp_edge_a: assert property (master && push |-> (smp_pol ? m_rise : m_fall))
        else $error("data sampled on wrong edge");
    fp_lead_a: assert property (master && fp_edge && !fp_kind && m_pos == fp_at |=> m_fp)
        else $error("frame pulse not set");
    fp_pol_a: assert property (tx_backplane_frame_pulse_oe && !m_fp |-> tx_backplane_frame_pulse_drive == fp_pol)
        else $error("frame pulse idle level wrong");
    err_set_a: assert property (err_evt |=> err_flag ##1 (err_flag || $past(err_clr)))
        else $error("error flag not set or not held");
    irq_out_a: assert property (err_flag && ctrl[`TBI_F_IRQEN] |-> !irq_n)
        else $error("interrupt not asserted");
    std_map_a: assert property (push && !master && mode != tbi_md_slv_t1 && scheme == tbi_sc_std && !mp_push_f
        |-> s_slot != 5'h0 && s_slot != 5'h10 && s_slot <= 5'h19)
        else $error("standard map kept a dropped slot");
    fill_map_a: assert property (push && !master && scheme == tbi_sc_fill && !mp_push_f |-> s_slot[1:0] != 2'h0)
        else $error("filler byte kept");
    cont_map_a: assert property (push && !master && scheme == tbi_sc_cont && !mp_push_f |-> s_slot <= 5'h18)
        else $error("continuous map kept slot above 24");
    line_out_a: assert property (rd |=> line_valid ##1 !line_valid)
        else $error("line strobe wrong");
endmodule : tbi_top

/* tbi_sys_model.sv */
`timescale 1ns/1ps
module tbi_sys_model (
    input wire logic ref_clk, // Block clock
    input wire logic en, // Backplane active
    input wire logic [9:0] frame_len, // Bits from pulse to pulse
    output logic bp_clk, // Backplane clock, 80 ns
    output logic bp_fp, // Frame pulse, active high
    output logic bp_data, // Payload bit
    output logic bp_sig // Signalling bit
);
    logic [2:0] ph = 3'h0;
    logic [9:0] pos = 10'h0;
    initial {bp_clk, bp_fp, bp_data, bp_sig} = 4'h0;
    // Eight block cycles a bit; pulse and data move one block cycle before the falling edge; when idle the clock stays low, other lines keep toggling
    always @(posedge ref_clk) begin
        ph <= en ? ph + 3'h1 : 3'h0;
        bp_clk <= en & (ph >= 3'h3 && ph <= 3'h6);
        if (!en) begin
            pos <= 10'h0;
            {bp_fp, bp_data, bp_sig} <= ~{bp_fp, bp_data, bp_sig};
        end else if (ph == 3'h6) begin
            pos <= (pos >= frame_len - 10'h1) ? 10'h0 : pos + 10'h1;
            bp_fp <= (pos >= frame_len - 10'h1);
            bp_data <= pos[0] ^ pos[3];
            bp_sig <= pos[1];
        end
    end
endmodule : tbi_sys_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, en = 1'b0, fp_idle = 1'b0;
    logic mux_on = 1'b0; // Parks the plain clock pin so only the mux bus clock can move data
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, q, avs_readdata;
    logic [9:0] flen = 10'h100;
    logic avs_waitrequest, tx_backplane_clock_drive, tx_backplane_clock_oe, tx_backplane_frame_pulse_drive;
    logic tx_backplane_frame_pulse_oe, line_data, line_sig, line_fmark, line_valid, irq_n, m_clk, m_fp, m_d, m_s;
    int fail_count = 0, n_checks = 0, n_clk, n_fp, n_val, n_fm, n_fz, tot;
    // Pin level is whoever drives it
    wire logic tx_backplane_clock = tx_backplane_clock_oe ? tx_backplane_clock_drive : m_clk & ~mux_on;
    wire logic tx_backplane_frame_pulse = tx_backplane_frame_pulse_oe ? tx_backplane_frame_pulse_drive : m_fp;
    // 100 MHz block clock
    always #5 ref_clk = ~ref_clk;
    tbi_top #(.FIFO_DEPTH(32)) dut_u (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .tx_backplane_clock, .tx_backplane_clock_drive, .tx_backplane_clock_oe,
        .tx_backplane_frame_pulse, .tx_backplane_frame_pulse_drive, .tx_backplane_frame_pulse_oe,
        .tx_backplane_serial_in(m_d), .tx_backplane_signalling_in(m_s), .mux_bus_clock(m_clk),
        .mux_bus_frame_pulse(m_fp), .mux_bus_serial_in(m_d), .mux_bus_signalling_in(m_s), .line_data,
        .line_sig, .line_fmark, .line_valid, .irq_n);
    tbi_sys_model sys_u (.ref_clk, .en, .frame_len(flen), .bp_clk(m_clk), .bp_fp(m_fp), .bp_data(m_d),
        .bp_sig(m_s));
    task automatic test_done;
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            test_done();
        end
        @(posedge ref_clk);
    endtask : bus
    // Counts clock rises, active pulse cycles, line bits and F-bits over a window
    task automatic watch(input int cyc);
        logic pc;
        {n_clk, n_fp, n_val, n_fm, n_fz} = '0;
        pc = tx_backplane_clock_drive;
        repeat (cyc) begin
            @(posedge ref_clk);
            n_clk += int'(tx_backplane_clock_drive === 1'b1 && pc === 1'b0);
            pc = tx_backplane_clock_drive;
            n_fp += int'(tx_backplane_frame_pulse_drive !== fp_idle);
            n_val += int'(line_valid === 1'b1);
            n_fm += int'(line_valid === 1'b1 && line_fmark === 1'b1);
            // Model data is zero at every bit that feeds an E1-rate F-bit
            n_fz += int'(line_valid === 1'b1 && line_fmark === 1'b1 && {line_data, line_sig} !== 2'b00);
        end
    endtask : watch
    task automatic t_regs;
        bus(0, 4'h0, 0);
        chk(q, 32'h0);
        bus(1, 4'h0, 32'hffffffff);
        bus(0, 4'h0, 0);
        chk(q, 32'h1fff);
        bus(1, 4'h0, 0);
        bus(1, 4'h2, 32'hffffffff);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
    endtask : t_regs
    task automatic t_master;
        chk(tx_backplane_clock_oe, 1);
        watch(12600);
        chk(32'(n_clk >= 193 && n_clk <= 196), 1);
        chk(32'(n_fp >= 60 && n_fp <= 140), 1);
        bus(1, 4'h0, 32'h90);
        fp_idle = 1'b1;
        watch(12600);
        chk(32'(n_fp >= 60 && n_fp <= 140), 1);
    endtask : t_master
    task automatic t_holes;
        bus(1, 4'h8, 32'hffffff);
        bus(1, 4'h0, 32'hc00);
        watch(200);
        watch(12600);
        chk(n_clk, 0);
        bus(1, 4'h8, 0);
        bus(1, 4'hc, 32'hffffff);
        bus(1, 4'h0, 32'h800);
        watch(200);
        watch(12600);
        chk(32'(n_clk >= 167 && n_clk <= 173), 1);
    endtask : t_holes
    task automatic t_slave;
        bus(1, 4'hc, 0);
        en <= 1'b1;
        tot = 0;
        for (int m = 1; m < 4; m++) begin
            bus(1, 4'h0, 32'h1032 | (m << 2));
            watch(m == 1 ? 3300 : 300); // First pass lets leftover master bits drain
            watch(6500);
            tot += n_fm;
            chk(n_fz, 0);
            chk(tx_backplane_clock_oe, 0);
            chk(32'(n_val >= 97 && n_val <= 104), 1);
        end
        chk(32'(tot > 0), 1);
        bus(1, 4'h4, 1);
        watch(4200);
        bus(0, 4'h4, 0);
        chk(q, 0);
        flen <= 10'h0fa;
        watch(6000);
        bus(0, 4'h4, 0);
        chk(q, 1);
        chk(irq_n, 0);
        flen <= 10'h100;
        watch(6200);
        bus(1, 4'h4, 1);
        bus(0, 4'h4, 0);
        chk(q, 0);
        chk(irq_n, 1);
    endtask : t_slave
    // Mux bus with 256-bit pulse spacing: data flows, spacing is flagged
    task automatic t_mux;
        bus(1, 4'h4, 1);
        mux_on <= 1'b1;
        bus(1, 4'h0, 32'h1035);
        watch(3000);
        watch(3300);
        chk(32'(n_val >= 49 && n_val <= 53), 1);
        chk(n_fz, 0);
        bus(0, 4'h4, 0);
        chk(q, 1);
        chk(irq_n, 0);
    endtask : t_mux
    // Reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_master();
        t_holes();
        t_slave();
        t_mux();
        test_done();
    end
endmodule : tb
